// *** src/clock_ctrl_pkg.sv ***
/*
 * Shared constants for the main clock generation and RC trim block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a single 125 MHz system clock.
 */
package clock_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
    localparam logic [7:0] OFS_RC_TRIM = 8'h04;
    localparam logic [7:0] OFS_OPTION = 8'h08;
    localparam logic [7:0] OFS_SI_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_FACTORY = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int SLOW_BIT = 0;
    localparam int CLKOUT_BIT = 1;
    localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
    localparam logic [7:0] RC_TRIM_RESET = 8'hFF;
    // Option: [2:0] source, [3] pll enable, [4] pll x8, [5] readout protect
    localparam int OPT_PLL_EN_BIT = 3;
    localparam int OPT_PLL_X8_BIT = 4;
    localparam int OPT_PROTECT_BIT = 5;
    localparam logic [5:0] OPTION_RESET = 6'h06;
    localparam int LOCK_BIT = 0;
    localparam int ACCURATE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Nonvolatile locations of factory trims
    localparam logic [15:0] NVM_TRIM_5V_ADDR = 16'hFFDE;
    localparam logic [15:0] NVM_TRIM_3V_ADDR = 16'hFFDF;
    localparam logic [15:0] NVM_TRIM_5V_COPY = 16'h1000;
    localparam logic [15:0] NVM_TRIM_3V_COPY = 16'h1001;
    localparam logic [7:0] NVM_ERASED = 8'hFF;

    // Source codes held in the option register
    localparam logic [2:0] SRC_EXT_CLOCK = 3'h0;
    localparam logic [2:0] SRC_XTAL_FIRST = 3'h1;
    localparam logic [2:0] SRC_XTAL_LAST = 3'h5;
    localparam logic [2:0] SRC_RC = 3'h6;
    localparam logic [2:0] SRC_ALT_PIN = 3'h7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int PLL_STARTUP_NS = 100000;
    localparam int PLL_SETTLE_NS = 200000;
    localparam int PLL_STARTUP_CYCLES = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_SETTLE_CYCLES = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOW_DIVIDE = 32;
    localparam logic [3:0] SLOW_HALF_LAST = 4'hF;

    typedef enum logic [1:0] {PLL_OFF, PLL_STARTING, PLL_SETTLING, PLL_ACCURATE} pll_state_t;

endpackage

// *** src/clock_source_ctrl.sv ***
/*
 * Main clock source selection, RC trim, PLL start/lock sequencing, slow
 * mode divider and clock output, with an AXI4-Lite register slave.
 * Assumes oscillator and PLL signals arrive asynchronously and are sampled
 * at 125 MHz, so modelled clocks are well below a quarter of that rate.
 */
// Functional notes
// - Reset always returns the RC trim register to FFh.
// - Trim 00h gives highest RC frequency, FFh lowest, monotonic between.
// - Factory trims for 5 V and 3 V kept in nonvolatile locations.
// - Clearing readout protection after it was set erases both factory trims.
// - PLL multiplies 1 MHz by 4 or 8, enabled and selected by option bits.
// - PLL off: RC on gives RC clock, RC off gives external clock.
// - PLL withholds its output for a startup delay after reset or wakeup.
// - Lock flag sets once PLL output reaches operating frequency.
// - Full PLL accuracy only after a further settle interval.
// - Main clock control resets to zero; upper six bits reserved and zero.
// - Clock out enable drives main clock on pin, else pin is free.
// - Slow mode feeds CPU the selected oscillator clock divided by 32.
// - Source chosen from external, five crystal ranges or internal RC.
// - Without multi-oscillator, external clock comes from the alternate pin.
// - Crystal oscillators keep running while reset is asserted.
`timescale 1ns/10ps
module clock_source_ctrl
    import clock_ctrl_pkg::*;
#(
    parameter int STARTUP_CYCLES = PLL_STARTUP_CYCLES,
    parameter int SETTLE_CYCLES = PLL_SETTLE_CYCLES,
    parameter logic [7:0] FACTORY_TRIM_5V = 8'h80,
    parameter logic [7:0] FACTORY_TRIM_3V = 8'h80
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Oscillator sources, asynchronous
    input wire logic osc_input_pin,
    input wire logic alt_ext_clock_pin,
    input wire logic rc_osc_in,
    input wire logic pll_in,
    // Halt or auto-wakeup exit pulse
    input wire logic halt_wakeup,
    // Analog control
    output logic [7:0] trim_bits,
    output logic xtal_enable,
    output logic [2:0] xtal_range,
    output logic pll_enable,
    output logic pll_x8,
    // Clocks and clock out pin
    output logic oscillator_clock,
    output logic cpu_clock,
    output logic clock_out_o,
    output logic clock_out_oe,
    // Status
    output logic pll_locked,
    output logic pll_accurate,
    output logic irq
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] src_meta_reg;
    logic [3:0] src_sync_reg;
    always_ff @(posedge aclk) begin
        src_meta_reg <= {pll_in, rc_osc_in, alt_ext_clock_pin, osc_input_pin};
        src_sync_reg <= src_meta_reg;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0] main_ctrl_reg;
    logic [7:0] rc_trim_reg;
    logic [5:0] option_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic trims_erased_reg;
    pll_state_t pll_state_reg;
    logic [31:0] pll_count_reg;
    logic locked_reg;
    logic accurate_reg;

    function automatic logic is_xtal(input logic [2:0] src);
        is_xtal = (src >= SRC_XTAL_FIRST) && (src <= SRC_XTAL_LAST);
    endfunction
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    wire aw_take = awvalid && !aw_held_reg && !bvalid_reg;
    wire w_take = wvalid && !w_held_reg && !bvalid_reg;
    wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_lane0 = wr_fire && w_strb_reg[0];
    wire wr_main = wr_lane0 && (aw_addr_reg == OFS_MAIN_CTRL);
    wire wr_trim = wr_lane0 && (aw_addr_reg == OFS_RC_TRIM);
    wire wr_opt = wr_lane0 && (aw_addr_reg == OFS_OPTION);
    wire wr_irqs = wr_lane0 && (aw_addr_reg == OFS_IRQ_STATUS);
    wire wr_mask = wr_lane0 && (aw_addr_reg == OFS_IRQ_MASK);
    wire wr_known = (aw_addr_reg == OFS_MAIN_CTRL) || (aw_addr_reg == OFS_RC_TRIM)
        || (aw_addr_reg == OFS_OPTION) || (aw_addr_reg == OFS_IRQ_STATUS)
        || (aw_addr_reg == OFS_IRQ_MASK) || (aw_addr_reg == OFS_SI_STATUS)
        || (aw_addr_reg == OFS_FACTORY);
    wire ar_take = arvalid && !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? 2'h0 : 2'h2;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Reserved bits above the fields read as zero
    logic [31:0] rd_value;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case ({araddr[7:2], 2'b00})
            OFS_MAIN_CTRL: rd_value = {30'h0, main_ctrl_reg};
            OFS_RC_TRIM: rd_value = {24'h0, rc_trim_reg};
            OFS_OPTION: rd_value = {26'h0, option_reg};
            OFS_SI_STATUS: rd_value = {30'h0, accurate_reg, locked_reg};
            OFS_IRQ_STATUS: rd_value = {30'h0, irq_status_reg};
            OFS_IRQ_MASK: rd_value = {30'h0, irq_mask_reg};
            OFS_FACTORY: rd_value = trims_erased_reg ? {16'h0, NVM_ERASED, NVM_ERASED}
                : {16'h0, FACTORY_TRIM_3V, FACTORY_TRIM_5V};
            default: begin
                rd_value = 32'h0000_0000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0000_0000;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_known ? 2'h0 : 2'h2;
            rdata_reg <= rd_value;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Reserved bits 7:2 of the control byte are dropped on write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_ctrl_reg <= MAIN_CTRL_RESET[1:0];
            rc_trim_reg <= RC_TRIM_RESET;
            irq_mask_reg <= IRQ_RESET;
        end else begin
            if (wr_main) main_ctrl_reg <= w_data_reg[1:0];
            if (wr_trim) rc_trim_reg <= w_data_reg[7:0];
            if (wr_mask) irq_mask_reg <= w_data_reg[1:0];
        end
    end

    // Option byte stands in for flash option bits; protect-clear erases trims
    wire protect_cleared = wr_opt && option_reg[OPT_PROTECT_BIT]
        && !w_data_reg[OPT_PROTECT_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_reg <= OPTION_RESET;
            trims_erased_reg <= 1'b0;
        end else begin
            if (wr_opt) option_reg <= w_data_reg[5:0];
            if (protect_cleared) trims_erased_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // PLL start and lock sequence
    // ----------------------------------------------------------------
    wire pll_on = option_reg[OPT_PLL_EN_BIT];
    wire [31:0] pll_count_inc = pll_count_reg + 32'h1;
    logic [31:0] pll_count_next;
    pll_state_t pll_state_next;
    always_comb begin
        pll_state_next = pll_state_reg;
        pll_count_next = pll_count_inc;
        case (pll_state_reg)
            PLL_OFF: begin
                pll_count_next = 32'h0;
                if (pll_on) pll_state_next = PLL_STARTING;
            end
            PLL_STARTING: if (pll_count_inc >= 32'(STARTUP_CYCLES)) begin
                pll_state_next = PLL_SETTLING;
                pll_count_next = 32'h0;
            end
            PLL_SETTLING: if (pll_count_inc >= 32'(SETTLE_CYCLES)) begin
                pll_state_next = PLL_ACCURATE;
                pll_count_next = 32'h0;
            end
            PLL_ACCURATE: pll_count_next = 32'h0;
            default: pll_state_next = PLL_OFF;
        endcase
        if (!pll_on || halt_wakeup) begin
            pll_state_next = PLL_OFF;
            pll_count_next = 32'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_state_reg <= PLL_OFF;
            pll_count_reg <= 32'h0;
            locked_reg <= 1'b0;
            accurate_reg <= 1'b0;
        end else begin
            pll_state_reg <= pll_state_next;
            pll_count_reg <= pll_count_next;
            locked_reg <= (pll_state_next == PLL_SETTLING)
                || (pll_state_next == PLL_ACCURATE);
            accurate_reg <= (pll_state_next == PLL_ACCURATE);
        end
    end

    // Events; a fresh event beats a same-cycle clear
    wire [1:0] irq_event = {(pll_state_next == PLL_ACCURATE) && (pll_state_reg == PLL_SETTLING),
        (pll_state_next == PLL_SETTLING) && (pll_state_reg == PLL_STARTING)};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_irqs ? w_data_reg[1:0] : 2'h0))
                | irq_event;
        end
    end

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    wire [2:0] src_sel = option_reg[2:0];
    wire src_rc = (src_sel == SRC_RC);
    // External input: osc pin for the multi-oscillator, else the alternate pin
    wire ext_clk = (src_sel == SRC_ALT_PIN) ? src_sync_reg[1] : src_sync_reg[0];
    wire base_clk = src_rc ? src_sync_reg[2] : ext_clk;
    // PLL output is held low until its startup delay has run out
    wire pll_out = locked_reg && src_sync_reg[3];
    wire osc_sel = pll_on ? pll_out : base_clk;

    // ----------------------------------------------------------------
    // Slow mode divider and outputs
    // ----------------------------------------------------------------
    logic osc_clk_reg;
    logic [3:0] slow_count_reg;
    logic slow_clk_reg;
    logic cpu_clk_reg;
    wire osc_edge = osc_sel && !osc_clk_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_clk_reg <= 1'b0;
            slow_count_reg <= 4'h0;
            slow_clk_reg <= 1'b0;
            cpu_clk_reg <= 1'b0;
        end else begin
            osc_clk_reg <= osc_sel;
            // Toggle every 16 input edges gives divide by 32
            if (osc_edge) begin
                slow_count_reg <= slow_count_reg + 4'h1;
                if (slow_count_reg == SLOW_HALF_LAST) slow_clk_reg <= ~slow_clk_reg;
            end
            cpu_clk_reg <= main_ctrl_reg[SLOW_BIT] ? slow_clk_reg : osc_sel;
        end
    end

    // Crystal enable keeps its value through reset so the resonator never stops
    logic xtal_en_reg;
    always_ff @(posedge aclk) begin
        if (aresetn) xtal_en_reg <= is_xtal(src_sel);
    end

    logic clk_out_reg;
    logic clk_oe_reg;
    logic irq_reg;
    logic [7:0] trim_out_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out_reg <= 1'b0;
            clk_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
            trim_out_reg <= RC_TRIM_RESET;
        end else begin
            clk_out_reg <= main_ctrl_reg[CLKOUT_BIT] && cpu_clk_reg;
            clk_oe_reg <= main_ctrl_reg[CLKOUT_BIT];
            irq_reg <= |(irq_status_reg & irq_mask_reg);
            // Analog RC slows as the code rises: 00h fastest, FFh slowest
            trim_out_reg <= rc_trim_reg;
        end
    end

    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign trim_bits = trim_out_reg;
    assign xtal_enable = xtal_en_reg;
    assign xtal_range = option_reg[2:0];
    assign pll_enable = option_reg[OPT_PLL_EN_BIT];
    assign pll_x8 = option_reg[OPT_PLL_X8_BIT];
    assign oscillator_clock = osc_clk_reg;
    assign cpu_clock = cpu_clk_reg;
    assign clock_out_o = clk_out_reg;
    assign clock_out_oe = clk_oe_reg;
    assign pll_locked = locked_reg;
    assign pll_accurate = accurate_reg;
    assign irq = irq_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence restart_s;
        halt_wakeup || !pll_on;
    endsequence

    trim_reset_a: assert property ($rose(aresetn) |-> rc_trim_reg == RC_TRIM_RESET)
        else $error("trim not FFh after reset");
    ctrl_zero_a: assert property ($rose(aresetn) |-> main_ctrl_reg == 2'h0)
        else $error("main control not zero after reset");
    lock_clear_a: assert property (restart_s |=> !locked_reg)
        else $error("lock stayed set over restart");
    lock_hold_a: assert property ($rose(locked_reg)
        |-> $past(pll_count_reg) == 32'(STARTUP_CYCLES - 1))
        else $error("lock during startup");
    lock_source_a: assert property ($rose(locked_reg)
        |-> $past(pll_state_reg) == PLL_STARTING)
        else $error("lock rose outside startup");
    accurate_after_a: assert property (accurate_reg |-> locked_reg)
        else $error("accurate without lock");
    pin_enable_a: assert property (clock_out_oe == $past(main_ctrl_reg[CLKOUT_BIT]))
        else $error("clock out enable mismatch");
    slow_clock_a: assert property (main_ctrl_reg[SLOW_BIT] && $past(main_ctrl_reg[SLOW_BIT])
        |=> cpu_clk_reg == $past(slow_clk_reg))
        else $error("cpu clock not divided in slow mode");
    erase_a: assert property (protect_cleared |=> trims_erased_reg)
        else $error("factory trims not erased");
    pll_gate_a: assert property (pll_on && !locked_reg |=> !osc_clk_reg)
        else $error("pll clock passed before startup");

endmodule

// *** testbench/osc_source_model.sv ***
/*
 * Far-side oscillator sources: crystal on the oscillator pin, alternate
 * external clock pin, trimmable RC oscillator and the PLL output.
 * Assumes ns time units; all half periods stay well above 16 ns.
 */
`timescale 1ns/10ps
module osc_source_model (
    // Controls from the block
    input wire logic xtal_enable,
    input wire logic pll_enable,
    input wire logic pll_x8,
    input wire logic [7:0] trim_bits,
    // Source levels
    output logic osc_input_pin,
    output logic alt_ext_clock_pin,
    output logic rc_osc_in,
    output logic pll_in
);
    // ------------------------------------------------------------
    // Free-running sources
    // ------------------------------------------------------------
    initial begin
        osc_input_pin = 1'b0;
        // Enable is not reset, so the crystal keeps swinging in reset
        forever begin
            #36;
            if (xtal_enable === 1'b1) begin
                osc_input_pin = ~osc_input_pin;
            end
        end
    end
    initial begin
        alt_ext_clock_pin = 1'b0;
        forever #44 alt_ext_clock_pin = ~alt_ext_clock_pin;
    end
    initial begin
        rc_osc_in = 1'b0;
        // Higher code, slower oscillator
        forever #(40 + trim_bits / 32) rc_osc_in = ~rc_osc_in;
    end
    initial begin
        pll_in = 1'b0;
        forever begin
            #(pll_x8 ? 24 : 48);
            if (pll_enable === 1'b1) begin
                pll_in = ~pll_in;
            end
        end
    end
endmodule

// *** testbench/clock_source_and_rc_calibration_bench.sv ***
/*
 * Self-checking bench for the clock source block: AXI4-Lite register
 * tasks and directed sequences. Assumes short PLL counts of 8 and 16.
 */
`timescale 1ns/10ps
module clock_source_and_rc_calibration_bench;
    import clock_ctrl_pkg::*;
    localparam int STU = 8;
    localparam int STB = 16;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_wakeup;
    logic [7:0] awaddr, araddr, trim_bits;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, osc_input_pin, alt_ext_clock_pin;
    logic rc_osc_in, pll_in, xtal_enable, pll_enable, pll_x8, oscillator_clock;
    logic [2:0] xtal_range;
    logic cpu_clock, clock_out_o, clock_out_oe, pll_locked, pll_accurate, irq;
    int error_cnt, total_checks, n;

    clock_source_ctrl #(.STARTUP_CYCLES(STU), .SETTLE_CYCLES(STB)) clock_source_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .osc_input_pin(osc_input_pin),
        .alt_ext_clock_pin(alt_ext_clock_pin), .rc_osc_in(rc_osc_in), .pll_in(pll_in),
        .halt_wakeup(halt_wakeup), .trim_bits(trim_bits), .xtal_enable(xtal_enable),
        .xtal_range(xtal_range), .pll_enable(pll_enable), .pll_x8(pll_x8),
        .oscillator_clock(oscillator_clock), .cpu_clock(cpu_clock),
        .clock_out_o(clock_out_o), .clock_out_oe(clock_out_oe), .pll_locked(pll_locked),
        .pll_accurate(pll_accurate), .irq(irq));

    osc_source_model osc_source_model_i (
        .xtal_enable(xtal_enable), .pll_enable(pll_enable), .pll_x8(pll_x8),
        .trim_bits(trim_bits), .osc_input_pin(osc_input_pin),
        .alt_ext_clock_pin(alt_ext_clock_pin), .rc_osc_in(rc_osc_in), .pll_in(pll_in));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            chk("wait bound", 32'h0, 32'h1);
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int k;
        logic a_on, w_on;
        a_on = 1'b1;
        w_on = 1'b1;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (a_on && awready === 1'b1) begin a_on = 1'b0; awvalid <= 1'b0; end
            if (w_on && wready === 1'b1) begin w_on = 1'b0; wvalid <= 1'b0; end
        end while (bvalid !== 1'b1 && k < 50);
        rs = bresp;
        bready <= 1'b0;
        give_up(k, 50);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int k;
        logic a_on;
        a_on = 1'b1;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (a_on && arready === 1'b1) begin a_on = 1'b0; arvalid <= 1'b0; end
        end while (rvalid !== 1'b1 && k < 50);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        give_up(k, 50);
    endtask

    task automatic wait_flag(input bit acc, output int k);
        k = 0;
        while ((acc ? pll_accurate : pll_locked) !== 1'b1 && k < 200) begin
            @(posedge aclk);
            k++;
        end
        give_up(k, 200);
    endtask

    // Oscillator rising edges within one cpu clock period
    task automatic count_div(output int c);
        int k, e;
        logic po, pc;
        c = 0;
        e = 0;
        k = 0;
        po = oscillator_clock;
        pc = cpu_clock;
        while (e < 2 && k < 5000) begin
            @(posedge aclk);
            k++;
            if (e == 1 && oscillator_clock === 1'b1 && po === 1'b0) c++;
            if (cpu_clock === 1'b1 && pc === 1'b0) e++;
            chk("clock out", clock_out_o, pc);
            po = oscillator_clock;
            pc = cpu_clock;
        end
        give_up(k, 5000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, halt_wakeup} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_MAIN_CTRL, d, r); chk("main ctrl reset", d, 32'h0);
        rd(OFS_RC_TRIM, d, r); chk("trim reset", d, 32'hFF);
        chk("trim pins reset", trim_bits, 32'hFF);
        rd(OFS_FACTORY, d, r); chk("factory trims", d, 32'h8080);
        rd(OFS_SI_STATUS, d, r); chk("si status reset", d, 32'h0);
        wr(OFS_RC_TRIM, 32'h80, r); rd(OFS_RC_TRIM, d, r); chk("trim write", d, 32'h80);
        repeat (2) @(posedge aclk);
        chk("trim pins", trim_bits, 32'h80);
        wr(OFS_MAIN_CTRL, 32'hFF, r); rd(OFS_MAIN_CTRL, d, r); chk("reserved", d, 32'h3);
        repeat (2) @(posedge aclk);
        chk("clock out on", clock_out_oe, 32'h1);
        wr(OFS_MAIN_CTRL, 32'h0, r);
        repeat (2) @(posedge aclk);
        chk("clock out off", clock_out_oe, 32'h0);
        rd(8'h1C, d, r); chk("unmapped read", {r, d[29:0]}, 32'h80000000);
        wr(8'h1C, 32'h1, r); chk("unmapped write", r, 32'h2);
        for (int s = 0; s < 2; s++) begin
            wr(OFS_MAIN_CTRL, s + 2, r);
            count_div(n); chk("cpu divide", n, s ? SLOW_DIVIDE : 1);
        end
        for (int c = 0; c < 8; c++) begin
            wr(OFS_OPTION, c, r);
            repeat (3) @(posedge aclk);
            chk("range", xtal_range, c);
            chk("crystal enable", xtal_enable, (c >= 1 && c <= 5));
        end
        wr(OFS_OPTION, 32'h1, r);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("crystal in reset", xtal_enable, 32'h1);
        aresetn <= 1'b1;
        rd(OFS_RC_TRIM, d, r); chk("trim after reset", d, 32'hFF);
        wr(OFS_OPTION, 32'h26, r);
        wr(OFS_OPTION, 32'h06, r);
        rd(OFS_FACTORY, d, r); chk("factory erased", d, 32'hFFFF);
        wr(OFS_OPTION, 32'h0E, r);
        chk("no early lock", pll_locked, 32'h0);
        chk("pll on x4", {pll_enable, pll_x8}, 32'h2);
        wait_flag(0, n); chk("lock delay", (n >= STU - 2 && n <= STU + 3), 32'h1);
        chk("not yet accurate", pll_accurate, 32'h0);
        wait_flag(1, n); chk("settle delay", (n >= STB - 2 && n <= STB + 3), 32'h1);
        rd(OFS_IRQ_STATUS, d, r); chk("irq status", d, 32'h3);
        chk("irq masked", irq, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk("irq raised", irq, 32'h1);
        wr(OFS_IRQ_STATUS, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk("irq cleared", irq, 32'h0);
        rd(OFS_IRQ_STATUS, d, r); chk("w1c", d, 32'h2);
        @(posedge aclk);
        halt_wakeup <= 1'b1;
        @(posedge aclk);
        halt_wakeup <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("relock cleared", {pll_locked, pll_accurate}, 32'h0);
        wait_flag(0, n); chk("relock delay", (n >= STU - 4 && n <= STU + 3), 32'h1);
        wr(OFS_OPTION, 32'h1E, r);
        chk("pll x8", pll_x8, 32'h1);
        finish_test();
    end
endmodule
